//--- umcl_defs.svh
`ifndef UMCL_DEFS_SVH
`define UMCL_DEFS_SVH

// ----------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------
`define UMCL_OFF_MCTL      3'h0
`define UMCL_OFF_LSTAT     3'h1
`define UMCL_OFF_INT_STAT  3'h2
`define UMCL_OFF_INT_CLR   3'h3
`define UMCL_OFF_INT_EN    3'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UMCL_MCTL_DTR      0
`define UMCL_MCTL_RTS      1
`define UMCL_MCTL_AUTOFLOW 5
`define UMCL_LSTAT_TEMT    6
`define UMCL_LSTAT_FERR    7
`define UMCL_INT_TEMT      0
`define UMCL_INT_FERR      1

// ----------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------
`define UMCL_MCTL_WMASK    8'h3F
`define UMCL_MCTL_RESET    8'h00
`define UMCL_INT_RESET     2'h0
`define UMCL_NUM_EVENTS    2

`endif

//--- umcl_pkg.sv
package umcl_pkg;

    // ----------------------------------------------------------------
    // Bus carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } umcl_avs_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } umcl_avs_rsp_s;

    // ----------------------------------------------------------------
    // Flow configurations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        UMCL_FLOW_OFF,
        UMCL_FLOW_CTS,
        UMCL_FLOW_RTS_CTS
    } umcl_flow_e;

    // ----------------------------------------------------------------
    // Module state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  mctl;
        logic        ferr;
        logic        temt;
        logic        rts_n;
        logic        dtr_n;
        logic        ack;
        logic [31:0] rdata;
    } umcl_top_s;

    typedef struct packed {
        logic [1:0] status;
        logic [1:0] enable;
        logic       irq;
    } umcl_irq_s;

endpackage : umcl_pkg

//--- umcl_flow.sv
`timescale 1ns/1ps
`include "umcl_defs.svh"

module umcl_flow
    import umcl_pkg::*;
(
    // Control bits
    input  wire logic        auto_flow_enable,
    input  wire logic        rts_bit,
    // Line side
    input  wire logic        cts_n,
    input  wire logic        rx_above,
    // Results
    output umcl_pkg::umcl_flow_e mode,
    output logic             tx_start_ok,
    output logic             rts_n_next
);
    import umcl_pkg::*;

    // ----------------------------------------------------------------
    // Flow decode
    // ----------------------------------------------------------------
    always_comb begin
        if (auto_flow_enable && rts_bit) begin
            mode = UMCL_FLOW_RTS_CTS;
        end else if (auto_flow_enable) begin
            mode = UMCL_FLOW_CTS;
        end else begin
            mode = UMCL_FLOW_OFF;
        end
    end

    assign tx_start_ok = (mode == UMCL_FLOW_OFF) || !cts_n;

    assign rts_n_next = !(rts_bit && !((mode == UMCL_FLOW_RTS_CTS) && rx_above));

endmodule : umcl_flow

//--- umcl_irq.sv
`timescale 1ns/1ps
`include "umcl_defs.svh"

module umcl_irq
    import umcl_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Events and software access
    input  wire logic [1:0] event_set,
    input  wire logic       clr_wr,
    input  wire logic       en_wr,
    input  wire logic [1:0] wdata,
    // Results
    output logic [1:0]      status,
    output logic [1:0]      enable,
    output logic            irq
);
    import umcl_pkg::*;

    umcl_irq_s st_reg;
    umcl_irq_s st_next;
    logic [1:0] stat_next;

    // ----------------------------------------------------------------
    // Sticky status, set wins over clear
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `UMCL_NUM_EVENTS; i++) begin : g_bit
            assign stat_next[i] = event_set[i] || (st_reg.status[i] && !(clr_wr && wdata[i]));
        end
    endgenerate

    always_comb begin
        st_next        = st_reg;
        st_next.status = stat_next;
        if (en_wr) begin
            st_next.enable = wdata;
        end
        st_next.irq    = |(stat_next & st_next.enable);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= '{status: `UMCL_INT_RESET, enable: `UMCL_INT_RESET, irq: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign status = st_reg.status;
    assign enable = st_reg.enable;
    assign irq    = st_reg.irq;

endmodule : umcl_irq

//--- umcl_top.sv
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "umcl_defs.svh"

// Contract
// - Request bit 0 drives request output high; bit 1 drives it low.
// - Ready bit 0 drives terminal-ready output high; bit 1 drives it low.
// - Auto-flow on with request bit set runs automatic request and clear.
// - Auto-flow on with request bit clear runs automatic clear only.
// - Auto-flow off disables both automatic modes regardless of request bit.
// - Status bit 7 set while an errored character sits in receive FIFO.
// - Reading line status clears the receive FIFO error flag.
// - Non-FIFO mode: bit 6 set when holding and shift registers empty.
// - Bit 6 cleared while holding or shift register holds a character.
// - FIFO mode: bit 6 set only when transmit FIFO and shifter empty.
// - Control bit 5 is auto-flow enable, combined with bit 1.
module umcl_top
    import umcl_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // Avalon-MM slave
    input  wire logic [2:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Modem lines
    input  wire logic        CTS_N,
    output logic             RTS_N,
    output logic             DTR_N,
    // Transmit side of the unit
    input  wire logic        FIFO_MODE,
    input  wire logic        TX_HOLD_EMPTY,
    input  wire logic        TX_SHIFT_EMPTY,
    input  wire logic        TX_FIFO_EMPTY,
    output logic             TX_START_OK,
    // Receive side of the unit
    input  wire logic        RX_ERR_PUSH,
    input  wire logic        RX_ERR_PRESENT,
    input  wire logic        RX_ABOVE_TRIGGER,
    // Interrupt
    output logic             IRQ
);
    import umcl_pkg::*;

    // ----------------------------------------------------------------
    // State and wiring
    // ----------------------------------------------------------------
    umcl_top_s     st_reg;
    umcl_top_s     st_next;
    umcl_avs_req_s req;
    umcl_avs_rsp_s rsp;
    umcl_flow_e    flow_mode;
    logic          rts_n_next;
    logic          done;
    logic          lstat_rd;
    logic          temt_now;
    logic          temt_rise;
    logic          ferr_rise;
    logic [1:0]    int_status;
    logic [1:0]    int_enable;
    logic [7:0]    lstat_value;

    assign req = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
                   writedata: AVS_WRITEDATA};

    // ----------------------------------------------------------------
    // Bus handshake: one wait cycle per access
    // ----------------------------------------------------------------
    assign done   = st_reg.ack && (req.read || req.write);
    assign lstat_rd = done && req.read && (req.address == `UMCL_OFF_LSTAT);

    assign rsp.waitrequest = (req.read || req.write) && !st_reg.ack;
    assign rsp.readdata    = st_reg.rdata;

    // ----------------------------------------------------------------
    // Flow control
    // ----------------------------------------------------------------
    umcl_flow u_flow (
        .auto_flow_enable (st_reg.mctl[`UMCL_MCTL_AUTOFLOW]),
        .rts_bit          (st_reg.mctl[`UMCL_MCTL_RTS]),
        .cts_n       (CTS_N),
        .rx_above    (RX_ABOVE_TRIGGER),
        .mode        (flow_mode),
        .tx_start_ok (TX_START_OK),
        .rts_n_next  (rts_n_next)
    );

    // ----------------------------------------------------------------
    // Transmitter empty source
    // ----------------------------------------------------------------
    always_comb begin
        if (FIFO_MODE) begin
            temt_now = TX_FIFO_EMPTY && TX_SHIFT_EMPTY;
        end else begin
            temt_now = TX_HOLD_EMPTY && TX_SHIFT_EMPTY;
        end
    end

    assign lstat_value = {st_reg.ferr, st_reg.temt, 6'h00};

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign temt_rise = st_next.temt && !st_reg.temt;
    assign ferr_rise = st_next.ferr && !st_reg.ferr;

    umcl_irq u_irq (
        .clk       (CLK),
        .reset     (RESET),
        .event_set ({ferr_rise, temt_rise}),
        .clr_wr    (done && req.write && (req.address == `UMCL_OFF_INT_CLR)),
        .en_wr     (done && req.write && (req.address == `UMCL_OFF_INT_EN)),
        .wdata     (req.writedata[1:0]),
        .status    (int_status),
        .enable    (int_enable),
        .irq       (IRQ)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next     = st_reg;
        st_next.ack = (req.read || req.write) && !st_reg.ack;
        if (done && req.write && (req.address == `UMCL_OFF_MCTL)) begin
            st_next.mctl = req.writedata[7:0] & `UMCL_MCTL_WMASK;
        end
        if (req.read && !st_reg.ack) begin
            if (req.address == `UMCL_OFF_MCTL) begin
                st_next.rdata = {24'h000000, st_reg.mctl};
            end else if (req.address == `UMCL_OFF_LSTAT) begin
                st_next.rdata = {24'h000000, lstat_value};
            end else if (req.address == `UMCL_OFF_INT_STAT) begin
                st_next.rdata = {30'h00000000, int_status};
            end else if (req.address == `UMCL_OFF_INT_EN) begin
                st_next.rdata = {30'h00000000, int_enable};
            end else begin
                st_next.rdata = 32'h00000000;
            end
        end
        st_next.ferr  = RX_ERR_PUSH || (RX_ERR_PRESENT && st_reg.ferr && !lstat_rd);
        st_next.temt  = temt_now;
        st_next.rts_n = rts_n_next;
        st_next.dtr_n = !st_reg.mctl[`UMCL_MCTL_DTR];
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            st_reg <= '{mctl: `UMCL_MCTL_RESET, ferr: 1'b0, temt: 1'b1, rts_n: 1'b1,
                        dtr_n: 1'b1, ack: 1'b0, rdata: 32'h00000000};
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign AVS_READDATA    = rsp.readdata;
    assign AVS_WAITREQUEST = rsp.waitrequest;
    assign RTS_N           = st_reg.rts_n;
    assign DTR_N           = st_reg.dtr_n;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // request output level
    rts_manual_a: assert property (@(posedge CLK) disable iff (RESET)
        (!st_reg.mctl[`UMCL_MCTL_AUTOFLOW]) |=> (RTS_N == !$past(st_reg.mctl[`UMCL_MCTL_RTS])))
        else $error("request output does not follow control bit");

    dtr_level_a: assert property (@(posedge CLK) disable iff (RESET)
        ##1 (DTR_N == !$past(st_reg.mctl[`UMCL_MCTL_DTR])))
        else $error("terminal-ready output does not follow control bit");

    flow_both_a: assert property (@(posedge CLK) disable iff (RESET)
        (st_reg.mctl[`UMCL_MCTL_AUTOFLOW] && st_reg.mctl[`UMCL_MCTL_RTS] && RX_ABOVE_TRIGGER)
        |=> RTS_N)
        else $error("automatic request mode did not raise request output");

    flow_cts_a: assert property (@(posedge CLK) disable iff (RESET)
        (st_reg.mctl[`UMCL_MCTL_AUTOFLOW] && !st_reg.mctl[`UMCL_MCTL_RTS])
        |-> (flow_mode == UMCL_FLOW_CTS) && (TX_START_OK == !CTS_N))
        else $error("clear-only mode wrong");

    flow_off_a: assert property (@(posedge CLK) disable iff (RESET)
        !st_reg.mctl[`UMCL_MCTL_AUTOFLOW] |-> TX_START_OK && (flow_mode == UMCL_FLOW_OFF))
        else $error("automatic modes active while disabled");

    ferr_set_a: assert property (@(posedge CLK) disable iff (RESET)
        RX_ERR_PUSH |=> st_reg.ferr ##1 (lstat_value[`UMCL_LSTAT_FERR] || !RX_ERR_PUSH))
        else $error("receive error flag not set");

    ferr_clear_a: assert property (@(posedge CLK) disable iff (RESET)
        (lstat_rd && !RX_ERR_PUSH) |=> !st_reg.ferr)
        else $error("receive error flag survived status read");

    temt_plain_a: assert property (@(posedge CLK) disable iff (RESET)
        (!FIFO_MODE && TX_HOLD_EMPTY && TX_SHIFT_EMPTY) |=> lstat_value[`UMCL_LSTAT_TEMT])
        else $error("empty flag not set in non-FIFO mode");

    temt_busy_a: assert property (@(posedge CLK) disable iff (RESET)
        (!TX_SHIFT_EMPTY || (!FIFO_MODE && !TX_HOLD_EMPTY)) |=> !st_reg.temt)
        else $error("empty flag set while a character is held");

    temt_fifo_a: assert property (@(posedge CLK) disable iff (RESET)
        (FIFO_MODE && !TX_FIFO_EMPTY) |=> !st_reg.temt)
        else $error("empty flag set with transmit FIFO not empty");

    cts_hold_a: assert property (@(posedge CLK) disable iff (RESET)
        (st_reg.mctl[`UMCL_MCTL_AUTOFLOW] && CTS_N) |-> !TX_START_OK)
        else $error("transmit allowed while clear input deasserted");

    // Bus answer timing
    bus_wait_a: assert property (@(posedge CLK) disable iff (RESET)
        ($rose(AVS_READ) || $rose(AVS_WRITE)) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("bus answer not after one wait cycle");

    // Interrupt level
    irq_level_a: assert property (@(posedge CLK) disable iff (RESET)
        ##1 (IRQ == |($past(int_status) & $past(int_enable)) || IRQ == |(int_status & int_enable)))
        else $error("interrupt output inconsistent with status and enable");

endmodule : umcl_top

//--- umcl_peer.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Peer modem on the control lines
// ----------------------------------------------------------------
module umcl_peer (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Bench command
    input  wire logic hold_req,
    // Modem lines
    input  wire logic rts_n,
    output logic      cts_n,
    output logic      may_send
);
    // Peer sends only while the unit asks for data
    assign may_send = !rts_n;

    // Clear-to-send follows the peer's own readiness one cycle late
    always_ff @(posedge clk) begin
        if (reset) begin
            cts_n <= 1'b0;
        end else begin
            cts_n <= hold_req;
        end
    end
endmodule : umcl_peer

//--- umcl_top_tb.sv
`timescale 1ns/1ps

module umcl_top_tb;
    import umcl_pkg::*;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        clk, reset, avs_read, avs_write, avs_waitrequest;
    logic [2:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        cts_n, rts_n, dtr_n, fifo_mode, tx_hold_empty, tx_shift_empty;
    logic        tx_fifo_empty, tx_start_ok, rx_err_push, rx_err_present;
    logic        rx_above_trigger, irq, peer_hold;
    logic        auto_flow, rts;
    int          miscompares, comparisons;

    umcl_top u_umcl_top (
        .CLK(clk), .RESET(reset), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .CTS_N(cts_n), .RTS_N(rts_n), .DTR_N(dtr_n), .FIFO_MODE(fifo_mode),
        .TX_HOLD_EMPTY(tx_hold_empty), .TX_SHIFT_EMPTY(tx_shift_empty),
        .TX_FIFO_EMPTY(tx_fifo_empty),
        .TX_START_OK(tx_start_ok), .RX_ERR_PUSH(rx_err_push),
        .RX_ERR_PRESENT(rx_err_present), .RX_ABOVE_TRIGGER(rx_above_trigger),
        .IRQ(irq)
    );

    umcl_peer u_umcl_peer (
        .clk(clk), .reset(reset), .hold_req(peer_hold), .rts_n(rts_n),
        .cts_n(cts_n), .may_send()
    );

    // ----------------------------------------------------------------
    // Clock, watchdog and closing
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = !clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        stop_test();
    end

    task stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    // ----------------------------------------------------------------
    // Compare and bus tasks
    // ----------------------------------------------------------------
    task check_data(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_data

    task check_pin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_pin

    task bus_access(input logic wr, input logic [2:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge clk);
        avs_address   <= addr;
        avs_writedata <= wdata;
        avs_write     <= wr;
        avs_read      <= !wr;
        n = 0;
        @(negedge clk);
        while (avs_waitrequest !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100) begin
            miscompares++;
            stop_test();
        end
        rd = avs_readdata;
        @(posedge clk);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus_access

    task read_check(input logic [2:0] addr, input logic [31:0] exp);
        bus_access(1'b0, addr, 32'h0);
        check_data(rd, exp);
    endtask : read_check

    task pulse_err();
        @(posedge clk);
        rx_err_push <= 1'b1;
        @(posedge clk);
        rx_err_push <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse_err

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        reset = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {fifo_mode, rx_err_push, rx_err_present, rx_above_trigger, peer_hold} = '0;
        {tx_hold_empty, tx_shift_empty, tx_fifo_empty} = 3'h7;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        check_pin(rts_n, 1'b1);
        check_pin(dtr_n, 1'b1);
        check_pin(irq, 1'b0);
        read_check(3'h0, 32'h00000000);
        read_check(3'h1, 32'h00000040);
        // Modem outputs for every ready/request bit combination
        for (int i = 0; i < 4; i++) begin
            bus_access(1'b1, 3'h0, 32'hC0 | i);
            repeat (3) @(posedge clk);
            check_pin(rts_n, !i[1]);
            check_pin(dtr_n, !i[0]);
            read_check(3'h0, 32'h0 | i);
        end
        // Flow configurations with peer stalling
        for (int i = 0; i < 4; i++) begin
            auto_flow = i[1];
            rts = i[0];
            for (int j = 0; j < 2; j++) begin
                bus_access(1'b1, 3'h0, {26'h0, auto_flow, 3'h0, rts, 1'b0});
                peer_hold        <= j[0];
                rx_above_trigger <= j[0];
                repeat (4) @(posedge clk);
                check_pin(tx_start_ok, !(auto_flow && j[0]));
                check_pin(rts_n, (auto_flow && rts && j[0]) ? 1'b1 : !rts);
            end
        end
        peer_hold        <= 1'b0;
        rx_above_trigger <= 1'b0;
        // Transmitter empty flag
        tx_hold_empty <= 1'b0;
        read_check(3'h1, 32'h00000000);
        tx_hold_empty <= 1'b1;
        tx_shift_empty <= 1'b0;
        read_check(3'h1, 32'h00000000);
        fifo_mode <= 1'b1;
        tx_hold_empty <= 1'b0;
        tx_shift_empty <= 1'b1;
        tx_fifo_empty <= 1'b0;
        read_check(3'h1, 32'h00000000);
        tx_fifo_empty <= 1'b1;
        read_check(3'h1, 32'h00000040);
        fifo_mode <= 1'b0;
        tx_hold_empty <= 1'b1;
        read_check(3'h1, 32'h00000040);
        // Receive error flag and its interrupt
        bus_access(1'b1, 3'h3, 32'h3);
        bus_access(1'b1, 3'h4, 32'h2);
        read_check(3'h4, 32'h00000002);
        rx_err_present <= 1'b1;
        pulse_err();
        check_pin(irq, 1'b1);
        read_check(3'h2, 32'h00000002);
        read_check(3'h1, 32'h000000C0);
        read_check(3'h1, 32'h00000040);
        bus_access(1'b1, 3'h3, 32'h2);
        repeat (2) @(posedge clk);
        check_pin(irq, 1'b0);
        read_check(3'h2, 32'h00000000);
        // Masked event sets status only
        bus_access(1'b1, 3'h4, 32'h0);
        pulse_err();
        check_pin(irq, 1'b0);
        read_check(3'h2, 32'h00000002);
        rx_err_present <= 1'b0;
        repeat (2) @(posedge clk);
        read_check(3'h1, 32'h00000040);
        // Unmapped and write-only places
        bus_access(1'b1, 3'h5, 32'hFF);
        read_check(3'h5, 32'h00000000);
        read_check(3'h3, 32'h00000000);
        stop_test();
    end
endmodule : umcl_top_tb
